// *** dv/esx_exec_properties.sv ***
// checker on the extended instruction executor ports
`timescale 1ns/1ps
module esx_props import esx_pkg::*; (
	input logic clk_sys_i,
	input logic rst_n_i,
	input logic instr_valid_i,
	input logic [15:0] instr_i,
	input logic busy_o,
	input logic ptr_we_o,
	input logic stack_push_o,
	input logic stack_pop_o,
	input logic flush_o,
	input logic mem_re_o,
	input logic mem_we_o,
	input logic [11:0] mem_waddr_o,
	input logic status_we_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	wire t = instr_valid_i && !busy_o;
	wire r = t && instr_i[15:6] == {OPC_ADD_PTR, SEL_STACK_RET};
	wire a = t && instr_i[15:8] == OPC_ADD_PTR && !r;
	wire m = t && instr_i[15:7] == OPC_MOVE_IDX;
	property p_call; t && instr_i == OPC_CALL_ACC |=> stack_push_o; endproperty
	a_call: assert property (p_call) else $error("call");
	property p_nop; stack_push_o |-> flush_o && busy_o ##1 !busy_o; endproperty
	a_nop: assert property (p_nop) else $error("nop");
	property p_ret; r |=> stack_pop_o && ptr_we_o ##1 !busy_o; endproperty
	a_ret: assert property (p_ret) else $error("ret");
	property p_add; a |=> ptr_we_o && !stack_pop_o && !busy_o; endproperty
	a_add: assert property (p_add) else $error("add");
	property p_rd; m |=> mem_re_o && busy_o; endproperty
	a_rd: assert property (p_rd) else $error("read");
	property p_wr; mem_we_o |-> $past(busy_o) && !busy_o; endproperty
	a_wr: assert property (p_wr) else $error("write");
	property p_dst;
		mem_we_o |-> mem_waddr_o < ADR_TOP_LOW && mem_waddr_o != ADR_PC_LOW;
	endproperty
	a_dst: assert property (p_dst) else $error("dest");
	property p_flag; !status_we_o; endproperty
	a_flag: assert property (p_flag) else $error("flag");
	cover property (r);
	cover property (m ##[1:9] mem_we_o);
	cover property (stack_push_o);
	cover property (mem_re_o && instr_valid_i && instr_i[15:12] == OPC_SECOND_WORD);
endmodule
bind esx_exec esx_props u_props (
	.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i),
	.instr_valid_i(instr_valid_i),
	.instr_i(instr_i),
	.busy_o(busy_o),
	.ptr_we_o(ptr_we_o),
	.stack_push_o(stack_push_o),
	.stack_pop_o(stack_pop_o),
	.flush_o(flush_o),
	.mem_re_o(mem_re_o),
	.mem_we_o(mem_we_o),
	.mem_waddr_o(mem_waddr_o),
	.status_we_o(status_we_o)
);

// *** dv/esx_exec_test.sv ***
// self-checking bench for the extended instruction executor
`timescale 1ns/1ps
module esx_exec_test import esx_pkg::*;;
	logic clk_sys_i = 0, rst_n_i = 0, instr_valid_i = 0, src_is_indirect_i;
	logic busy_o, ptr_we_o, stack_push_o, pc_load_o, mem_re_o, mem_we_o;
	logic [1:0] ptr_sel_o;
	logic [7:0] acc_i = 0, pc_latch_high_i = 0, pc_latch_upper_i = 0;
	logic [7:0] mem_rdata_i, mem_wdata_o;
	logic [11:0] ptr0_i = 0, ptr1_i = 0, software_stack_pointer_i = 0;
	logic [11:0] ptr_wdata_o, mem_raddr_o, mem_waddr_o, e, d;
	logic [15:0] instr_i = 0;
	logic [20:0] pc_i = 0, return_stack_top_i = 0, stack_push_data_o, pc_wdata_o;
	logic [23:0] q[$];
	int error_cnt = 0, n_compared = 0, cyc = 0;
	esx_exec dut_u (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.instr_valid_i(instr_valid_i),
		.instr_i(instr_i),
		.pc_i(pc_i),
		.acc_i(acc_i),
		.pc_latch_high_i(pc_latch_high_i),
		.pc_latch_upper_i(pc_latch_upper_i),
		.return_stack_top_i(return_stack_top_i),
		.ptr0_i(ptr0_i),
		.ptr1_i(ptr1_i),
		.software_stack_pointer_i(software_stack_pointer_i),
		.mem_rdata_i(mem_rdata_i),
		.src_is_indirect_i(src_is_indirect_i),
		.busy_o(busy_o),
		.ptr_we_o(ptr_we_o),
		.ptr_sel_o(ptr_sel_o),
		.ptr_wdata_o(ptr_wdata_o),
		.stack_push_o(stack_push_o),
		.stack_push_data_o(stack_push_data_o),
		.stack_pop_o(),
		.pc_load_o(pc_load_o),
		.pc_wdata_o(pc_wdata_o),
		.flush_o(),
		.mem_re_o(mem_re_o),
		.mem_raddr_o(mem_raddr_o),
		.mem_we_o(mem_we_o),
		.mem_waddr_o(mem_waddr_o),
		.mem_wdata_o(mem_wdata_o),
		.status_we_o()
	);
	esx_mem mem_u (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.mem_re_o(mem_re_o),
		.mem_raddr_o(mem_raddr_o),
		.mem_rdata_i(mem_rdata_i),
		.src_is_indirect_i(src_is_indirect_i)
	);
	always #12.5 clk_sys_i = ~clk_sys_i;
	task ex(input logic [2:0] k, input logic [20:0] v);
		q.push_back({k, v});
	endtask
	task chk(input logic [23:0] v);
		logic [23:0] x;
		x = q.size() ? q.pop_front() : 24'hFFFFFF;
		n_compared++;
		if (x !== v) begin
			error_cnt++;
			$display("mismatch %0t exp %h got %h", $time, x, v);
		end
	endtask
	task chk_ptr;
		chk({3'h1, 7'h0, ptr_sel_o, ptr_wdata_o});
	endtask
	task chk_push;
		chk({3'h2, stack_push_data_o});
	endtask
	task chk_pc;
		chk({3'h3, pc_wdata_o});
	endtask
	task chk_rd;
		chk({3'h5, 9'h0, mem_raddr_o});
	endtask
	task chk_wr;
		chk({3'h4, 1'h0, mem_waddr_o, mem_wdata_o});
	endtask
	task test_done;
		if (q.size()) error_cnt++;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task op(input logic [15:0] w, input int n, input int idle);
		instr_i = w;
		instr_valid_i = 1;
		repeat (n) @(posedge clk_sys_i);
		#2;
		if (idle > 0) begin
			instr_valid_i = 0;
			repeat (idle) @(posedge clk_sys_i);
			#2;
		end
	endtask
	always @(posedge clk_sys_i) begin
		#1;
		if (ptr_we_o === 1'h1) chk_ptr;
		if (stack_push_o === 1'h1) chk_push;
		if (pc_load_o === 1'h1) chk_pc;
		if (mem_re_o === 1'h1) chk_rd;
		if (mem_we_o === 1'h1) chk_wr;
		if (++cyc > 999) begin
			error_cnt++;
			test_done;
		end
	end
	initial begin
		void'($urandom(32'h5BD8E642));
		repeat (20) @(posedge clk_sys_i);
		#2 rst_n_i = 1;
		for (int i = 0; i < 8; i++) begin
			{pc_i, acc_i, pc_latch_high_i, pc_latch_upper_i, return_stack_top_i,
				ptr0_i, ptr1_i, software_stack_pointer_i} =
				102'({$urandom, $urandom, $urandom, $urandom});
			software_stack_pointer_i[11] = 0;
			ex(2, pc_i + PC_STEP);
			ex(3, {pc_latch_upper_i[4:0], pc_latch_high_i, acc_i});
			op(OPC_CALL_ACC, 2, 2);
			e = software_stack_pointer_i + acc_i[5:0];
			ex(1, {7'h0, SEL_STACK_PTR, e});
			ex(3, return_stack_top_i);
			op({OPC_ADD_PTR, SEL_STACK_RET, acc_i[5:0]}, 2, 2);
			for (int f = 0; f < 3; f++) begin
				e = f == 0 ? ptr0_i : f == 1 ? ptr1_i : software_stack_pointer_i;
				ex(1, {7'h0, f[1:0], e + acc_i[7:2]});
				op({OPC_ADD_PTR, f[1:0], acc_i[7:2]}, 1, 2);
			end
			for (int j = 0; j < 3; j++) begin
				d = j == 0 ? pc_i[18:7] & 12'h7FF : j == 1 ? 12'hFF8 : ADR_TOP_LOW;
				if (j == 1) software_stack_pointer_i = 12'hFE0 - pc_i[6:0];
				e = software_stack_pointer_i + pc_i[6:0];
				ex(5, {9'h0, e});
				if (j < 2) ex(4, {1'h0, d, j ? 8'h00 : e[7:0] ^ 8'h5A});
				op({OPC_MOVE_IDX, pc_i[6:0]}, 1, j == 1 ? 0 : 2);
				op({OPC_SECOND_WORD, d}, 1, 2);
			end
			$display("test %0d done", i);
		end
		test_done;
	end
endmodule

// *** dv/esx_mem.sv ***
// data memory seen by the executor, answers one cycle late
`timescale 1ns/1ps
module esx_mem #(parameter logic [7:0] IND_PAGE = 8'hFE) (
	input logic clk_sys_i,
	input logic rst_n_i,
	input logic mem_re_o,
	input logic [11:0] mem_raddr_o,
	output logic [7:0] mem_rdata_i,
	output logic src_is_indirect_i
);
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem_rdata_i <= 8'h00;
			src_is_indirect_i <= 1'h0;
		end else if (mem_re_o) begin
			mem_rdata_i <= mem_raddr_o[7:0] ^ 8'h5A;
			src_is_indirect_i <= mem_raddr_o[11:4] == IND_PAGE;
		end
	end
endmodule

// *** hw/esx_decode.sv ***
// opcode classifier for the extended instructions
`timescale 1ns/1ps
module esx_decode
	import esx_pkg::*;
(
	input wire logic [15:0] instr_i,
	output logic is_add_o,
	output logic is_add_ret_o,
	output logic is_call_o,
	output logic is_move_o
);
	always_comb begin
		is_add_o = (instr_i[15:OPC_POS] == OPC_ADD_PTR) &&
			(instr_i[SEL_POS+:2] != SEL_STACK_RET);
		is_add_ret_o = (instr_i[15:OPC_POS] == OPC_ADD_PTR) &&
			(instr_i[SEL_POS+:2] == SEL_STACK_RET);
		is_call_o = (instr_i == OPC_CALL_ACC);
		is_move_o = (instr_i[15:OFS_W] == OPC_MOVE_IDX);
	end
endmodule

// *** hw/esx_exec.sv ***
// extended instruction executor: decode, sequencing and output registers
`timescale 1ns/1ps
module esx_exec
	import esx_pkg::*;
#(
	parameter int PTR_W = ADDR_W
)(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic instr_valid_i,
	input wire logic [15:0] instr_i,
	input wire logic [PC_W-1:0] pc_i,
	input wire logic [7:0] acc_i,
	input wire logic [7:0] pc_latch_high_i,
	input wire logic [7:0] pc_latch_upper_i,
	input wire logic [PC_W-1:0] return_stack_top_i,
	input wire logic [PTR_W-1:0] ptr0_i,
	input wire logic [PTR_W-1:0] ptr1_i,
	input wire logic [PTR_W-1:0] software_stack_pointer_i,
	input wire logic [7:0] mem_rdata_i,
	input wire logic src_is_indirect_i,
	output logic busy_o,
	output logic ptr_we_o,
	output logic [1:0] ptr_sel_o,
	output logic [PTR_W-1:0] ptr_wdata_o,
	output logic stack_push_o,
	output logic [PC_W-1:0] stack_push_data_o,
	output logic stack_pop_o,
	output logic pc_load_o,
	output logic [PC_W-1:0] pc_wdata_o,
	output logic flush_o,
	output logic mem_re_o,
	output logic [ADDR_W-1:0] mem_raddr_o,
	output logic mem_we_o,
	output logic [ADDR_W-1:0] mem_waddr_o,
	output logic [7:0] mem_wdata_o,
	output logic status_we_o
);
	typedef struct packed {
		esx_state_t st;
		logic ptr_we;
		logic [1:0] ptr_sel;
		logic [PTR_W-1:0] ptr_wdata;
		logic push;
		logic [PC_W-1:0] push_data;
		logic pop;
		logic pc_load;
		logic [PC_W-1:0] pc_wdata;
		logic flush;
		logic re;
		logic [ADDR_W-1:0] raddr;
		logic we;
		logic [ADDR_W-1:0] waddr;
		logic [7:0] wdata;
		logic src_ready;
		logic dst_pending;
		logic [ADDR_W-1:0] dst_addr;
	} esx_regs_t;

	esx_regs_t r;
	esx_regs_t next_r;
	logic is_add;
	logic is_add_ret;
	logic is_call;
	logic is_move;
	logic take_dst;
	logic [ADDR_W-1:0] dst;

	esx_decode u_decode (
		.instr_i(instr_i),
		.is_add_o(is_add),
		.is_add_ret_o(is_add_ret),
		.is_call_o(is_call),
		.is_move_o(is_move)
	);

	function automatic logic protected_dst(input logic [ADDR_W-1:0] a);
		protected_dst = (a == ADR_PC_LOW) || (a == ADR_TOP_LOW) ||
			(a == ADR_TOP_HIGH) || (a == ADR_TOP_UPPER);
	endfunction

	function automatic logic [1:0] sel_of(input logic [15:0] w);
		sel_of = w[SEL_POS+:2];
	endfunction

	function automatic logic [PTR_W-1:0] lit_of(input logic [15:0] w);
		lit_of = PTR_W'(w[LIT_W-1:0]);
	endfunction

	function automatic logic [PTR_W-1:0] ofs_of(input logic [15:0] w);
		ofs_of = PTR_W'(w[OFS_W-1:0]);
	endfunction

	function automatic logic [ADDR_W-1:0] dst_of(input logic [15:0] w);
		dst_of = w[ADDR_W-1:0];
	endfunction

	function automatic logic [PTR_W-1:0] ptr_of(input logic [1:0] s,
		input logic [PTR_W-1:0] p0, input logic [PTR_W-1:0] p1,
		input logic [PTR_W-1:0] p2);
		if (s == SEL_PTR0) begin
			ptr_of = p0;
		end else if (s == SEL_PTR1) begin
			ptr_of = p1;
		end else begin
			ptr_of = p2;
		end
	endfunction

	always_comb begin
		next_r = r;
		next_r.ptr_we = 1'b0;
		next_r.push = 1'b0;
		next_r.pop = 1'b0;
		next_r.pc_load = 1'b0;
		next_r.flush = 1'b0;
		next_r.re = 1'b0;
		next_r.we = 1'b0;
		// a destination word may come before the source data
		take_dst = instr_valid_i && !r.dst_pending &&
			(instr_i[15:PREFIX_POS] == OPC_SECOND_WORD);
		dst = r.dst_pending ? r.dst_addr : dst_of(instr_i);
		unique case (r.st)
			ESX_IDLE: begin
				if (instr_valid_i && is_add) begin
					next_r.ptr_we = 1'b1;
					next_r.ptr_sel = sel_of(instr_i);
					next_r.ptr_wdata = ptr_of(sel_of(instr_i), ptr0_i, ptr1_i,
						software_stack_pointer_i) + lit_of(instr_i);
				end else if (instr_valid_i && is_add_ret) begin
					next_r.ptr_we = 1'b1;
					next_r.ptr_sel = SEL_STACK_PTR;
					next_r.ptr_wdata = software_stack_pointer_i +
						lit_of(instr_i);
					next_r.pop = 1'b1;
					next_r.pc_load = 1'b1;
					next_r.pc_wdata = return_stack_top_i;
					next_r.flush = 1'b1;
					next_r.st = ESX_NOP;
				end else if (instr_valid_i && is_call) begin
					next_r.push = 1'b1;
					next_r.push_data = pc_i + PC_STEP;
					next_r.pc_load = 1'b1;
					next_r.pc_wdata = {pc_latch_upper_i[UPPER_W-1:0],
						pc_latch_high_i, acc_i};
					next_r.flush = 1'b1;
					next_r.st = ESX_NOP;
				end else if (instr_valid_i && is_move) begin
					next_r.re = 1'b1;
					next_r.raddr = ADDR_W'(software_stack_pointer_i +
						ofs_of(instr_i));
					next_r.src_ready = 1'b0;
					next_r.dst_pending = 1'b0;
					next_r.st = ESX_MOVE_DST;
				end
			end
			ESX_NOP: begin
				next_r.st = ESX_IDLE;
			end
			ESX_MOVE_DST: begin
				// source data stands from the cycle after the read
				if (r.re) begin
					next_r.src_ready = 1'b1;
				end
				if (take_dst) begin
					next_r.dst_pending = 1'b1;
					next_r.dst_addr = dst_of(instr_i);
				end
				if (r.src_ready && (r.dst_pending || take_dst)) begin
					next_r.waddr = dst;
					next_r.we = !protected_dst(dst);
					next_r.wdata = src_is_indirect_i ?
						INDIRECT_READ_VALUE : mem_rdata_i;
					next_r.src_ready = 1'b0;
					next_r.dst_pending = 1'b0;
					next_r.st = ESX_IDLE;
				end
			end
			default: next_r.st = ESX_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// outputs straight from the register copy, except busy_o which is decoded from the state and status_we_o which is tied low
	assign busy_o = (r.st != ESX_IDLE);
	assign ptr_we_o = r.ptr_we;
	assign ptr_sel_o = r.ptr_sel;
	assign ptr_wdata_o = r.ptr_wdata;
	assign stack_push_o = r.push;
	assign stack_push_data_o = r.push_data;
	assign stack_pop_o = r.pop;
	assign pc_load_o = r.pc_load;
	assign pc_wdata_o = r.pc_wdata;
	assign flush_o = r.flush;
	assign mem_re_o = r.re;
	assign mem_raddr_o = r.raddr;
	assign mem_we_o = r.we;
	assign mem_waddr_o = r.waddr;
	assign mem_wdata_o = r.wdata;
	assign status_we_o = 1'b0;
endmodule

// *** hw/esx_pkg.sv ***
// constants and types shared by the extended instruction executor
package esx_pkg;
	localparam int ADDR_W = 12;
	localparam int PC_W = 21;
	localparam logic [7:0] OPC_ADD_PTR = 8'hE8;
	localparam logic [8:0] OPC_MOVE_IDX = 9'h1D6;
	localparam logic [3:0] OPC_SECOND_WORD = 4'hF;
	localparam logic [15:0] OPC_CALL_ACC = 16'h0014;
	// instruction word field positions and widths
	localparam int OPC_POS = 8;
	localparam int SEL_POS = 6;
	localparam int LIT_W = 6;
	localparam int OFS_W = 7;
	localparam int PREFIX_POS = 12;
	localparam int UPPER_W = 5;
	localparam logic [1:0] SEL_PTR0 = 2'h0;
	localparam logic [1:0] SEL_PTR1 = 2'h1;
	localparam logic [1:0] SEL_STACK_RET = 2'h3;
	localparam logic [1:0] SEL_STACK_PTR = 2'h2;
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
	localparam logic [7:0] INDIRECT_READ_VALUE = 8'h00;
	// protected destinations: pc low byte and return stack top bytes
	localparam logic [ADDR_W-1:0] ADR_PC_LOW = 12'hFF9;
	localparam logic [ADDR_W-1:0] ADR_TOP_LOW = 12'hFFD;
	localparam logic [ADDR_W-1:0] ADR_TOP_HIGH = 12'hFFE;
	localparam logic [ADDR_W-1:0] ADR_TOP_UPPER = 12'hFFF;
	typedef enum logic [1:0] {ESX_IDLE, ESX_NOP, ESX_MOVE_DST} esx_state_t;
endpackage
